// file: hw/pin_reset_sync.sv
/*
 * two-stage synchroniser for the external reset pin.
 * assumes the pin has an internal pull-up so a floating pin reads high.
 */
`timescale 1ns/1ps

module pin_reset_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// pin side
	input wire logic external_reset_n,
	// synchronised level, high means reset asserted
	output logic pinResetActive
);

	logic meta_q;
	logic sync_q;

	// first stage only feeds the second
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_q <= 1'h1;
			sync_q <= 1'h1;
		end else begin
			meta_q <= external_reset_n;
			sync_q <= meta_q;
		end
	end

	assign pinResetActive = !sync_q;

endmodule

// file: hw/reset_and_sdo_protection.sv
/*
 * reset sequencing and serial data output overvoltage protection.
 * assumes the power-up comparator level and channel control are synchronous to clk;
 * rst_b is the clock-domain reset and is driven by the power-up reset source.
 */
`timescale 1ns/1ps
`include "reset_sdo_defines.svh"

// Functional notes
// - overvoltage turns serial output driver off
// - re-enable driver on chip select rise
// - sticky overvoltage flag, cleared by read
// - low supply: reset, three-state, pump off
// - supply good: logic, serial, outputs run
// - overcurrent shutdown stays active when running
// - external reset active low, floating deasserted
// - external reset suppresses open-load detection
// - external reset keeps charge pump off
// - separate sticky power-up and pin flags
// - internal reset is OR of both
// - channels default low side, N-channel
// - outputs three-state until enable set
// - enabled channel follows its control
// - reset disables outputs, clears diagnostics
// - charge pump only with both released
// - enable bit gates each driver
module reset_and_sdo_protection (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// supply and reset sources
	input wire logic supplyAboveRelease,
	input wire logic ioSupplyStable,
	input wire logic external_reset_n,
	// spi side
	input wire logic chip_select_n,
	input wire logic serialOutOvervoltage,
	input wire logic serialOutData,
	input wire logic readPowerUpFlag,
	input wire logic readPinFlag,
	input wire logic readOvervoltageFlag,
	output logic serialOutO,
	output logic serialOutOe,
	output logic spiAccept,
	// flags
	output logic power_up_flag,
	output logic pin_reset_flag,
	output logic serial_out_overvoltage_flag,
	// channel configuration and control
	input wire logic cfgWrite,
	input wire reset_sdo_pkg::chanVec_t cfgSideHigh,
	input wire reset_sdo_pkg::chanVec_t cfgFetP,
	input wire reset_sdo_pkg::chanVec_t channel_output_enable,
	input wire reset_sdo_pkg::chanVec_t channelControl,
	input wire reset_sdo_pkg::chanVec_t overcurrentDetect,
	input wire logic openLoadRaw,
	output reset_sdo_pkg::chanVec_t chanSideHigh,
	output reset_sdo_pkg::chanVec_t chanFetP,
	output reset_sdo_pkg::chanVec_t chanDrive,
	output reset_sdo_pkg::chanVec_t chanDriveOe,
	output reset_sdo_pkg::chanVec_t overcurrentLatched,
	// analog controls
	output logic chargePumpEnable,
	output logic openLoadRegOn,
	output logic openLoadFail,
	output logic internalReset
);

	// ****************************************
	// reset combination
	// ****************************************
	logic pinResetActive;
	logic porActive;
	logic wasInReset_q;
	logic csPrev_q;
	logic csRise;
	reset_sdo_pkg::serialOutState_t soState_q;
	reset_sdo_pkg::serialOutState_t soState_d;
	reset_sdo_pkg::chanVec_t enable_q;

	pin_reset_sync uSync (
		.clk(clk),
		.rst_b(rst_b),
		.external_reset_n(external_reset_n),
		.pinResetActive(pinResetActive)
	);

	assign porActive = !rst_b || !supplyAboveRelease;
	assign internalReset = porActive || pinResetActive;
	assign chargePumpEnable = !internalReset;
	assign openLoadRegOn = !internalReset;
	assign spiAccept = !porActive && ioSupplyStable;

	// ****************************************
	// sticky reset flags, set beats clear
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			power_up_flag <= 1'h1;
			pin_reset_flag <= 1'h0;
			wasInReset_q <= 1'h1;
		end else begin
			wasInReset_q <= porActive;
			if (porActive || wasInReset_q) begin
				power_up_flag <= 1'h1;
			end else if (readPowerUpFlag) begin
				power_up_flag <= 1'h0;
			end
			if (pinResetActive) begin
				pin_reset_flag <= 1'h1;
			end else if (readPinFlag) begin
				pin_reset_flag <= 1'h0;
			end
		end
	end

	// ****************************************
	// serial output guard
	// ****************************************
	assign csRise = chip_select_n && !csPrev_q;

	always_comb begin
		soState_d = soState_q;
		case (soState_q)
			reset_sdo_pkg::SO_ACTIVE: begin
				if (serialOutOvervoltage) begin
					soState_d = reset_sdo_pkg::SO_TRIPPED;
				end
			end
			reset_sdo_pkg::SO_TRIPPED: begin
				if (!serialOutOvervoltage) begin
					soState_d = reset_sdo_pkg::SO_WAIT_CS;
				end
			end
			reset_sdo_pkg::SO_WAIT_CS: begin
				if (serialOutOvervoltage) begin
					soState_d = reset_sdo_pkg::SO_TRIPPED;
				end else if (csRise) begin
					soState_d = reset_sdo_pkg::SO_ACTIVE;
				end
			end
			default: begin
				soState_d = reset_sdo_pkg::SO_TRIPPED;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b || internalReset) begin
			soState_q <= reset_sdo_pkg::SO_ACTIVE;
			csPrev_q <= 1'h1;
		end else begin
			soState_q <= soState_d;
			csPrev_q <= chip_select_n;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || internalReset) begin
			serial_out_overvoltage_flag <= 1'h0;
		end else if (serialOutOvervoltage) begin
			serial_out_overvoltage_flag <= 1'h1;
		end else if (readOvervoltageFlag) begin
			serial_out_overvoltage_flag <= 1'h0;
		end
	end

	// driver off the same cycle overvoltage is seen; also blocks back-feed
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			serialOutO <= 1'h0;
		end else begin
			serialOutO <= serialOutData;
		end
	end
	assign serialOutOe = spiAccept && !chip_select_n && !serialOutOvervoltage
		&& soState_q == reset_sdo_pkg::SO_ACTIVE;

	// ****************************************
	// channel configuration and drive
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_b || internalReset) begin
			chanSideHigh <= {`RSD_NUM_CH{`RSD_SIDE_LOW}};
			chanFetP <= {`RSD_NUM_CH{`RSD_FET_N}};
			enable_q <= `RSD_CH_ALL_OFF;
		end else if (cfgWrite) begin
			chanSideHigh <= cfgSideHigh;
			chanFetP <= cfgFetP;
			enable_q <= channel_output_enable;
		end
	end

	// overcurrent latch lives whenever reset is released, even near threshold
	always_ff @(posedge clk) begin
		if (!rst_b || internalReset) begin
			overcurrentLatched <= `RSD_CH_ALL_OFF;
		end else begin
			overcurrentLatched <= overcurrentLatched | overcurrentDetect;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < `RSD_NUM_CH; ch++) begin : gCh
			always_ff @(posedge clk) begin
				if (!rst_b || internalReset) begin
					chanDrive[ch] <= 1'h0;
				end else begin
					chanDrive[ch] <= channelControl[ch] && !overcurrentDetect[ch]
						&& !overcurrentLatched[ch];
				end
			end
			// combinational so reset turns drivers off at once
			assign chanDriveOe[ch] = enable_q[ch] && !internalReset;
		end
	endgenerate

	assign openLoadFail = openLoadRaw && !internalReset;

	// ****************************************
	// checks
	// ****************************************
	sequence sTrip;
		serialOutOvervoltage;
	endsequence

	sequence sClearThenRise;
		!serialOutOvervoltage ##1 !serialOutOvervoltage && csRise;
	endsequence

	a_ov_driver_off: assert property (@(posedge clk) disable iff (!rst_b)
		sTrip |-> !serialOutOe)
		else $error("serial output driven during overvoltage");
	a_reenable_needs_cs: assert property (@(posedge clk) disable iff (!rst_b || internalReset)
		soState_q == reset_sdo_pkg::SO_WAIT_CS && !csRise && !serialOutOvervoltage
		|=> soState_q == reset_sdo_pkg::SO_WAIT_CS)
		else $error("serial output re-enabled without chip select rise");
	a_reenable_on_cs: assert property (@(posedge clk) disable iff (!rst_b || internalReset)
		soState_q == reset_sdo_pkg::SO_WAIT_CS ##0 sClearThenRise
		|=> soState_q == reset_sdo_pkg::SO_ACTIVE)
		else $error("serial output not re-enabled on chip select rise");
	a_ov_flag_set: assert property (@(posedge clk) disable iff (!rst_b || internalReset)
		serialOutOvervoltage ##1 !internalReset |-> serial_out_overvoltage_flag)
		else $error("overvoltage flag not set");
	a_pump_off_reset: assert property (@(posedge clk) disable iff (!rst_b)
		pinResetActive |-> !chargePumpEnable && !openLoadFail)
		else $error("pump or open-load active in pin reset");
	a_outputs_off_reset: assert property (@(posedge clk) disable iff (!rst_b)
		internalReset |-> chanDriveOe == `RSD_CH_ALL_OFF ##1 chanDrive == `RSD_CH_ALL_OFF)
		else $error("outputs live during reset");
	a_pin_flag_sticky: assert property (@(posedge clk) disable iff (!rst_b)
		pinResetActive |=> pin_reset_flag)
		else $error("pin reset flag not set");
	a_default_config: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(internalReset) |-> chanSideHigh == `RSD_CH_ALL_OFF && chanFetP == `RSD_CH_ALL_OFF)
		else $error("channel configuration not default after reset");

endmodule

// file: hw/reset_sdo_defines.svh
/*
 * constants for the reset and serial-output protection block.
 * assumes inclusion by bare name from the package and the design files.
 */
`ifndef RESET_SDO_DEFINES_SVH
`define RESET_SDO_DEFINES_SVH

// ****************************************
// widths and reset values
// ****************************************
`define RSD_NUM_CH 8
`define RSD_CH_ALL_OFF 8'h00
`define RSD_SIDE_LOW 1'h0
`define RSD_FET_N 1'h0
`define RSD_CFG_RESET 2'h0

`endif

// file: hw/reset_sdo_pkg.sv
/*
 * types for the reset and serial-output protection block.
 * assumes reset_sdo_defines.svh is on the include path.
 */
`include "reset_sdo_defines.svh"

package reset_sdo_pkg;

	// ****************************************
	// serial output guard states, one bit apart except SO_WAIT_CS to SO_ACTIVE
	// ****************************************
	typedef enum logic [1:0] {
		SO_ACTIVE = 2'h0,
		SO_TRIPPED = 2'h1,
		SO_WAIT_CS = 2'h3
	} serialOutState_t;

	typedef logic [`RSD_NUM_CH-1:0] chanVec_t;

endpackage

// file: testbench/reset_and_sdo_protection_tb.sv
/*
 * self-checking bench for the reset and serial output protection block.
 * assumes the design package and header are compiled first.
 */
`timescale 1ns/1ps

module reset_and_sdo_protection_tb;
	// ****************************************
	// bench
	// ****************************************
	logic clk, rstB, supplyOk, ovIn, cfgWr, olRaw, sdoOe, accept, pwrF, pinF, ovF, pump, olFail, iRst;
	logic csN, pinN, ioOk, sdoData, sdoQ, olReg;
	logic [2:0] rd;
	reset_sdo_pkg::chanVec_t side, fet, en, ctl, ocIn, sideQ, fetQ, drv, oe, ocQ;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;

	spi_host_model host (.clk(clk), .chip_select_n(csN), .external_reset_n(pinN), .readPulse(rd));

	reset_and_sdo_protection dut_u (.clk(clk), .rst_b(rstB), .supplyAboveRelease(supplyOk),
		.ioSupplyStable(ioOk), .external_reset_n(pinN), .chip_select_n(csN),
		.serialOutOvervoltage(ovIn), .serialOutData(sdoData), .readPowerUpFlag(rd[0]),
		.readPinFlag(rd[1]), .readOvervoltageFlag(rd[2]), .serialOutO(sdoQ), .serialOutOe(sdoOe),
		.spiAccept(accept), .power_up_flag(pwrF), .pin_reset_flag(pinF),
		.serial_out_overvoltage_flag(ovF), .cfgWrite(cfgWr), .cfgSideHigh(side),
		.cfgFetP(fet), .channel_output_enable(en), .channelControl(ctl),
		.overcurrentDetect(ocIn), .openLoadRaw(olRaw), .chanSideHigh(sideQ),
		.chanFetP(fetQ), .chanDrive(drv), .chanDriveOe(oe), .overcurrentLatched(ocQ),
		.chargePumpEnable(pump), .openLoadRegOn(olReg), .openLoadFail(olFail),
		.internalReset(iRst));

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// a hang costs a mismatch; the full run needs about 73 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	initial begin
		rstB = 1'h0;
		supplyOk = 1'h1;
		ioOk = 1'h1;
		sdoData = 1'h0;
		ovIn = 1'h0;
		cfgWr = 1'h0;
		olRaw = 1'h1;
		side = 8'h0f;
		fet = 8'h03;
		en = 8'hff;
		ctl = 8'ha5;
		ocIn = 8'h00;
		tick(16);
		chk("power flag", {7'h0, pwrF}, 8'h01);
		chk("drive oe", oe, 8'h00);
		chk("pump", {7'h0, pump}, 8'h00);
		chk("ol reg", {7'h0, olReg}, 8'h00);
		@(posedge clk) rstB <= 1'h1;
		tick(2);
		chk("pump", {7'h0, pump}, 8'h01);
		chk("ol reg", {7'h0, olReg}, 8'h01);
		chk("open load", {7'h0, olFail}, 8'h01);
		chk("accept", {7'h0, accept}, 8'h01);
		chk("side", sideQ, 8'h00);
		chk("fet", fetQ, 8'h00);
		chk("drive oe", oe, 8'h00);
		host.read_flag(3'h1);
		tick(2);
		chk("power flag", {7'h0, pwrF}, 8'h00);
		$display("test reset done");
		@(posedge clk) cfgWr <= 1'h1;
		@(posedge clk) cfgWr <= 1'h0;
		tick(2);
		chk("side", sideQ, 8'h0f);
		chk("fet", fetQ, 8'h03);
		chk("drive oe", oe, 8'hff);
		chk("drive", drv, 8'ha5);
		@(posedge clk) ocIn <= 8'h01;
		tick(2);
		chk("overcurrent", ocQ, 8'h01);
		chk("drive", drv, 8'ha4);
		$display("test channels done");
		host.pin(1'h0);
		tick(3);
		chk("int reset", {7'h0, iRst}, 8'h01);
		chk("drive oe", oe, 8'h00);
		chk("overcurrent", ocQ, 8'h00);
		chk("pump", {7'h0, pump}, 8'h00);
		chk("open load", {7'h0, olFail}, 8'h00);
		chk("pin flag", {7'h0, pinF}, 8'h01);
		host.pin(1'h1);
		tick(3);
		chk("int reset", {7'h0, iRst}, 8'h00);
		host.read_flag(3'h2);
		tick(2);
		chk("pin flag", {7'h0, pinF}, 8'h00);
		chk("side", sideQ, 8'h00);
		chk("drive oe", oe, 8'h00);
		// host reconfigures after a reset, with other enables and controls
		@(posedge clk);
		ctl <= 8'h3c;
		en <= 8'h0f;
		cfgWr <= 1'h1;
		@(posedge clk) cfgWr <= 1'h0;
		tick(2);
		chk("drive oe", oe, 8'h0f);
		chk("drive", drv, 8'h3c);
		@(posedge clk) supplyOk <= 1'h0;
		tick(1);
		chk("int reset", {7'h0, iRst}, 8'h01);
		chk("accept", {7'h0, accept}, 8'h00);
		chk("ol reg", {7'h0, olReg}, 8'h00);
		@(posedge clk) supplyOk <= 1'h1;
		tick(2);
		chk("power flag", {7'h0, pwrF}, 8'h01);
		$display("test resets done");
		@(posedge clk) ioOk <= 1'h0;
		host.frame(1'h0);
		tick(1);
		chk("accept", {7'h0, accept}, 8'h00);
		chk("sdo oe", {7'h0, sdoOe}, 8'h00);
		@(posedge clk);
		ioOk <= 1'h1;
		sdoData <= 1'h1;
		tick(1);
		chk("sdo oe", {7'h0, sdoOe}, 8'h01);
		chk("sdo data", {7'h0, sdoQ}, 8'h01);
		@(posedge clk) ovIn <= 1'h1;
		tick(2);
		chk("sdo oe", {7'h0, sdoOe}, 8'h00);
		chk("ov flag", {7'h0, ovF}, 8'h01);
		@(posedge clk) ovIn <= 1'h0;
		tick(3);
		chk("sdo oe", {7'h0, sdoOe}, 8'h00);
		host.frame(1'h1);
		host.frame(1'h0);
		tick(2);
		chk("sdo oe", {7'h0, sdoOe}, 8'h01);
		chk("ov flag", {7'h0, ovF}, 8'h01);
		host.read_flag(3'h4);
		tick(2);
		chk("ov flag", {7'h0, ovF}, 8'h00);
		@(posedge clk) olRaw <= 1'h0;
		tick(1);
		chk("open load", {7'h0, olFail}, 8'h00);
		$display("test overvoltage done");
		end_of_test();
	end
endmodule

// file: testbench/spi_host_model.sv
/*
 * spi host and ecu supply reset model for the reset block bench.
 * assumes tasks are called from one bench process, never at the same edge twice.
 */
`timescale 1ns/1ps

module spi_host_model (
	// clock
	input wire logic clk,
	// spi and reset lines
	output logic chip_select_n,
	output logic external_reset_n,
	output logic [2:0] readPulse
);
	// ****************************************
	// host actions
	// ****************************************
	// the pin idles high, as the on-chip pull-up would hold it
	initial begin
		chip_select_n = 1'h1;
		external_reset_n = 1'h1;
		readPulse = 3'h0;
	end
	task automatic frame(input logic lvl);
		@(posedge clk);
		chip_select_n <= lvl;
	endtask
	task automatic pin(input logic lvl);
		@(posedge clk);
		external_reset_n <= lvl;
	endtask
	// clearing read lasts one cycle: bit 0 power-up, 1 pin, 2 overvoltage
	task automatic read_flag(input logic [2:0] sel);
		@(posedge clk);
		readPulse <= sel;
		@(posedge clk);
		readPulse <= 3'h0;
	endtask
endmodule
